// [src/sld_pkg.sv]
package sld_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NCH = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_SYS_DIAG_REQ = 8'h00;
  localparam logic [7:0] ADDR_LOOP_DIAG_REQ = 8'h04;
  localparam logic [7:0] ADDR_LOOP_DIAG_STAT = 8'h08;
  localparam logic [7:0] ADDR_GND_LOSS = 8'h0c;
  localparam logic [7:0] ADDR_DIAG_CTRL = 8'h10;
  localparam logic [7:0] ADDR_ADC_RESULT = 8'h14;
  localparam logic [7:0] ADDR_DEPLOY_CFG0 = 8'h20;

  // system_diag_request fields
  localparam int SYS_FET_LSB = 0;
  localparam int SYS_TMR_LSB = 4;
  localparam logic [1:0] FET_CODE_HS = 2'h1;
  localparam logic [1:0] FET_CODE_LS = 2'h2;
  localparam logic [1:0] TMR_CODE_SEQ = 2'h1;
  localparam logic [1:0] TMR_CODE_BUF = 2'h2;

  // loop_diag_request fields
  localparam int LDR_RES_CH_LSB = 0;
  localparam int LDR_LEAK_CH_LSB = 4;
  localparam int LDR_MON_EN = 8;
  localparam int LDR_PD_ALL = 9;
  localparam int LDR_RES_MEAS = 10;
  localparam int LDR_MODE_LSB = 11;
  localparam int LDR_DEPLOY_DIAG = 13;
  localparam logic [1:0] MODE_CROSS_PAIR = 2'h3;
  localparam logic [13:0] LDR_RESET = 14'h0000;

  // deploy_config_register fields
  localparam int DCR_TIME_W = 7;
  localparam int DCR_CR_BIT = 7;
  localparam int DCR_PROG_BIT = 8;

  // Times in ns and derived cycle counts
  localparam int LKG_DEGLITCH_NS = 10000;
  localparam int FET_DEGLITCH_NS = 2000;
  localparam int GND_OPEN_FILT_NS = 20000;
  localparam int DEPLOY_UNIT_NS = 64000;
  localparam int DEFAULT_PULSE_NS = 8000;
  localparam int FET_TIMEOUT_NS = 500000;
  localparam int TIMER_GAP_NS = 8000000;
  localparam int LKG_DEGLITCH_CYC = (LKG_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FET_DEGLITCH_CYC = (FET_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GND_OPEN_FILT_CYC = (GND_OPEN_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEPLOY_UNIT_CYC = DEPLOY_UNIT_NS / CLK_PERIOD_NS;
  localparam int DEFAULT_PULSE_CYC = DEFAULT_PULSE_NS / CLK_PERIOD_NS;
  localparam int FET_TIMEOUT_CYC = FET_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int TIMER_GAP_CYC = (TIMER_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sld_bus_req_s;

  typedef struct packed {
    logic prog;
    logic common_ret;
    logic [DCR_TIME_W-1:0] dtime;
  } sld_dcr_s;
endpackage

// [src/sld_top.sv]
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module sld_top #(
  parameter int FET_TO_CYC = sld_pkg::FET_TIMEOUT_CYC,
  parameter int GAP_CYC = sld_pkg::TIMER_GAP_CYC,
  parameter int GND_FILT_CYC = sld_pkg::GND_OPEN_FILT_CYC,
  parameter int ADC_W = 10
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic diag_phase_in,
  input wire logic hs_thr_cmp_in,
  input wire logic ls_thr_cmp_in,
  input wire logic gnd_open_cmp_in,
  input wire logic adc_done_in,
  input wire logic [ADC_W-1:0] adc_data_in,
  input wire logic fire_enable_pin_in,
  output logic fire_enable_pin_out,
  output logic fire_enable_pin_oe_out,
  output logic hs_fet_on_out,
  output logic ls_fet_on_out,
  output logic [2:0] fet_ch_out,
  output logic mon_en_out,
  output logic fet_deglitch_sel_out,
  output logic [sld_pkg::NCH-1:0] pulldown_off_out,
  output logic source_en_out,
  output logic [2:0] source_ch_out,
  output logic [2:0] amp_ch_out,
  output logic adc_req_out
);
  localparam int NSYNC = 6 + ADC_W;
  localparam int TW = 24;

  typedef enum logic [1:0] {
    F_IDLE = 2'b01,
    F_RUN = 2'b10
  } sld_fet_e;
  typedef enum logic [3:0] {
    T_IDLE = 4'b0001,
    T_PULSE = 4'b0010,
    T_GAP = 4'b0100,
    T_BUF = 4'b1000
  } sld_tmr_e;

  logic rst_s1_r, rstn_r;
  logic [NSYNC-1:0] sync1_r, sync2_r;
  sld_pkg::sld_bus_req_s req;
  logic diag_ph, hs_cmp, ls_cmp, gnd_cmp, adc_done, fire_pin;
  logic [ADC_W-1:0] adc_data;

  logic [13:0] ldr_r;
  logic [3:0] res_ch, leak_ch;
  logic mon_en, pd_all, res_meas, deploy_diag;
  logic [1:0] ldr_mode;
  sld_pkg::sld_dcr_s dcr_r [sld_pkg::NCH];

  sld_fet_e fet_st_r;
  logic fet_is_hs_r;
  logic [31:0] fet_to_cnt_r;
  logic stb_flag_r, stg_flag_r, fet_res_valid_r;
  logic [15:0] dg_cnt_r [2];
  logic [1:0] dg_trip;
  logic dg_sel_d_r;
  logic [15:0] dg_lim;

  logic [15:0] gnd_cnt_r;
  logic [sld_pkg::NCH-1:0] gnd_loss_r;
  logic gnd_trip;

  logic adc_done_d_r;
  logic [ADC_W-1:0] adc_res_r;

  sld_tmr_e tmr_st_r;
  logic [2:0] tmr_ch_r;
  logic [TW-1:0] tmr_cnt_r;
  logic [TW-1:0] pulse_len;

  logic sys_wr, ldr_wr, ctrl_wr, gl_rd, fet_start, fet_stop, tmr_start, buf_start;
  logic [1:0] fet_code, tmr_code;
  logic [31:0] rdata_nxt;
  logic [sld_pkg::NCH-1:0] pd_nxt;

  // Reset release through two flops
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_r <= 1'b0;
      rstn_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rstn_r <= rst_s1_r;
    end
  end

  // ADC data is only sampled after the synced done edge, so skew settles
  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {adc_data_in, fire_enable_pin_in, adc_done_in, gnd_open_cmp_in,
                  ls_thr_cmp_in, hs_thr_cmp_in, diag_phase_in};
      sync2_r <= sync1_r;
    end
  end

  assign diag_ph = sync2_r[0];
  assign hs_cmp = sync2_r[1];
  assign ls_cmp = sync2_r[2];
  assign gnd_cmp = sync2_r[3];
  assign adc_done = sync2_r[4];
  assign fire_pin = sync2_r[5];
  assign adc_data = sync2_r[NSYNC-1:6];

  assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
  assign sys_wr = req.wr && (req.addr == sld_pkg::ADDR_SYS_DIAG_REQ);
  assign ldr_wr = req.wr && (req.addr == sld_pkg::ADDR_LOOP_DIAG_REQ);
  assign ctrl_wr = req.wr && (req.addr == sld_pkg::ADDR_DIAG_CTRL);
  assign gl_rd = req.rd && (req.addr == sld_pkg::ADDR_GND_LOSS);
  assign fet_code = req.wdata[sld_pkg::SYS_FET_LSB +: 2];
  assign tmr_code = req.wdata[sld_pkg::SYS_TMR_LSB +: 2];

  assign res_ch = ldr_r[sld_pkg::LDR_RES_CH_LSB +: 4];
  assign leak_ch = ldr_r[sld_pkg::LDR_LEAK_CH_LSB +: 4];
  assign mon_en = ldr_r[sld_pkg::LDR_MON_EN];
  assign pd_all = ldr_r[sld_pkg::LDR_PD_ALL];
  assign res_meas = ldr_r[sld_pkg::LDR_RES_MEAS];
  assign ldr_mode = ldr_r[sld_pkg::LDR_MODE_LSB +: 2];
  assign deploy_diag = ldr_r[sld_pkg::LDR_DEPLOY_DIAG];

  // Loop diag request register
  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      ldr_r <= sld_pkg::LDR_RESET;
    end else if (ldr_wr) begin
      ldr_r <= req.wdata[13:0];
    end
  end

  // Deploy config registers, common-return bit only held on even entries
  generate
    for (genvar i = 0; i < sld_pkg::NCH; i++) begin : g_dcr
      always_ff @(posedge mclk_in or negedge rstn_r) begin
        if (!rstn_r) begin
          dcr_r[i] <= '0;
        end else if (req.wr && (req.addr == sld_pkg::ADDR_DEPLOY_CFG0 + 8'(4 * i))) begin
          dcr_r[i].dtime <= req.wdata[sld_pkg::DCR_TIME_W-1:0];
          dcr_r[i].common_ret <= ((i % 2) == 0) ? req.wdata[sld_pkg::DCR_CR_BIT] : 1'b0;
          dcr_r[i].prog <= 1'b1;
        end
      end
    end
  endgenerate

  // FET test control
  // Request is refused unless in diag phase, monitor enabled and idle
  assign fet_start = sys_wr && diag_ph && mon_en && (fet_st_r == F_IDLE) &&
                     ((fet_code == sld_pkg::FET_CODE_HS) ||
                      (fet_code == sld_pkg::FET_CODE_LS));
  assign fet_stop = (fet_st_r == F_RUN) &&
                    ((|dg_trip) || (fet_to_cnt_r >= 32'(FET_TO_CYC - 1)));

  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      fet_st_r <= F_IDLE;
      fet_is_hs_r <= 1'b0;
      fet_to_cnt_r <= '0;
    end else begin
      case (fet_st_r)
        F_IDLE: begin
          fet_to_cnt_r <= '0;
          if (fet_start) begin
            fet_st_r <= F_RUN;
            fet_is_hs_r <= (fet_code == sld_pkg::FET_CODE_HS);
          end
        end
        F_RUN: begin
          fet_to_cnt_r <= fet_to_cnt_r + 32'h1;
          if (fet_stop) begin
            fet_st_r <= F_IDLE;
          end
        end
        default: fet_st_r <= F_IDLE;
      endcase
    end
  end

  // Driver enables and FET-on follow the run state, dropped on the stop cycle
  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      hs_fet_on_out <= 1'b0;
      ls_fet_on_out <= 1'b0;
      fet_deglitch_sel_out <= 1'b0;
    end else begin
      hs_fet_on_out <= fet_start ? (fet_code == sld_pkg::FET_CODE_HS)
                     : (hs_fet_on_out && !fet_stop);
      ls_fet_on_out <= fet_start ? (fet_code == sld_pkg::FET_CODE_LS)
                     : (ls_fet_on_out && !fet_stop);
      fet_deglitch_sel_out <= fet_start || ((fet_st_r == F_RUN) && !fet_stop);
    end
  end

  // Deglitch filters: entry 0 sourced current, entry 1 sunk current
  assign dg_lim = dg_sel_d_r ? 16'(sld_pkg::FET_DEGLITCH_CYC)
                             : 16'(sld_pkg::LKG_DEGLITCH_CYC);

  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      dg_sel_d_r <= 1'b0;
    end else begin
      dg_sel_d_r <= fet_deglitch_sel_out;
    end
  end

  generate
    for (genvar k = 0; k < 2; k++) begin : g_dg
      logic cmp;
      assign cmp = (k == 0) ? hs_cmp : ls_cmp;
      always_ff @(posedge mclk_in or negedge rstn_r) begin
        if (!rstn_r) begin
          dg_cnt_r[k] <= '0;
        end else if ((dg_sel_d_r != fet_deglitch_sel_out) || !cmp) begin
          dg_cnt_r[k] <= '0;
        end else if (dg_cnt_r[k] < dg_lim) begin
          dg_cnt_r[k] <= dg_cnt_r[k] + 16'h1;
        end
      end
      // Trip only armed while the FET deglitch time is active
      assign dg_trip[k] = (dg_cnt_r[k] == dg_lim) && dg_sel_d_r &&
                          (fet_st_r == F_RUN);
    end
  endgenerate

  // Latched FET result flags; a trip wins over a clearing write
  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      stb_flag_r <= 1'b0;
      stg_flag_r <= 1'b0;
      fet_res_valid_r <= 1'b0;
    end else begin
      if (sys_wr || ldr_wr) begin
        stb_flag_r <= 1'b0;
        stg_flag_r <= 1'b0;
        fet_res_valid_r <= 1'b0;
      end
      if (fet_start) begin
        fet_res_valid_r <= 1'b1;
      end
      if (dg_trip[0]) begin
        stb_flag_r <= 1'b1;
      end
      if (dg_trip[1]) begin
        stg_flag_r <= 1'b1;
      end
    end
  end

  // Ground loss filter, only during a resistance measurement
  assign gnd_trip = res_meas && (gnd_cnt_r == 16'(GND_FILT_CYC));

  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      gnd_cnt_r <= '0;
    end else if (!res_meas || !gnd_cmp) begin
      gnd_cnt_r <= '0;
    end else if (gnd_cnt_r < 16'(GND_FILT_CYC)) begin
      gnd_cnt_r <= gnd_cnt_r + 16'h1;
    end
  end

  generate
    for (genvar g = 0; g < sld_pkg::NCH; g++) begin : g_gl
      always_ff @(posedge mclk_in or negedge rstn_r) begin
        if (!rstn_r) begin
          gnd_loss_r[g] <= 1'b0;
        end else if (gnd_trip && (res_ch[2:0] == 3'(g))) begin
          gnd_loss_r[g] <= 1'b1;
        end else if (gl_rd) begin
          gnd_loss_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Safing node measurement request and capture
  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      adc_req_out <= 1'b0;
      adc_done_d_r <= 1'b0;
      adc_res_r <= '0;
    end else begin
      adc_req_out <= ctrl_wr;
      adc_done_d_r <= adc_done;
      if (adc_done && !adc_done_d_r) begin
        adc_res_r <= adc_data;
      end
    end
  end

  // Deployment timer test sequencer
  assign tmr_start = sys_wr && diag_ph && (tmr_code == sld_pkg::TMR_CODE_SEQ);
  assign buf_start = sys_wr && diag_ph && (tmr_code == sld_pkg::TMR_CODE_BUF);
  assign pulse_len = dcr_r[tmr_ch_r].prog
                   ? TW'(dcr_r[tmr_ch_r].dtime) * TW'(sld_pkg::DEPLOY_UNIT_CYC)
                   : TW'(sld_pkg::DEFAULT_PULSE_CYC);

  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      tmr_st_r <= T_IDLE;
      tmr_ch_r <= '0;
      tmr_cnt_r <= '0;
      fire_enable_pin_out <= 1'b0;
      fire_enable_pin_oe_out <= 1'b0;
    end else begin
      case (tmr_st_r)
        T_IDLE: begin
          tmr_cnt_r <= '0;
          tmr_ch_r <= '0;
          fire_enable_pin_out <= 1'b0;
          fire_enable_pin_oe_out <= 1'b0;
          if (tmr_start) begin
            tmr_st_r <= T_PULSE;
            fire_enable_pin_out <= 1'b1;
            fire_enable_pin_oe_out <= 1'b1;
          end else if (buf_start) begin
            tmr_st_r <= T_BUF;
            fire_enable_pin_out <= 1'b1;
            fire_enable_pin_oe_out <= 1'b1;
          end
        end
        T_PULSE: begin
          // Zero programmed time still gives a one-cycle pulse
          if (tmr_cnt_r + TW'(1) >= pulse_len) begin
            tmr_cnt_r <= '0;
            fire_enable_pin_out <= 1'b0;
            if (tmr_ch_r == 3'(sld_pkg::NCH - 1)) begin
              tmr_st_r <= T_IDLE;
              fire_enable_pin_oe_out <= 1'b0;
            end else begin
              tmr_st_r <= T_GAP;
            end
          end else begin
            tmr_cnt_r <= tmr_cnt_r + TW'(1);
          end
        end
        T_GAP: begin
          if (tmr_cnt_r + TW'(1) >= TW'(GAP_CYC)) begin
            tmr_cnt_r <= '0;
            tmr_ch_r <= tmr_ch_r + 3'h1;
            tmr_st_r <= T_PULSE;
            fire_enable_pin_out <= 1'b1;
          end else begin
            tmr_cnt_r <= tmr_cnt_r + TW'(1);
          end
        end
        T_BUF: begin
          if (tmr_cnt_r + TW'(1) >= TW'(sld_pkg::DEFAULT_PULSE_CYC)) begin
            tmr_st_r <= T_IDLE;
            fire_enable_pin_out <= 1'b0;
            fire_enable_pin_oe_out <= 1'b0;
          end else begin
            tmr_cnt_r <= tmr_cnt_r + TW'(1);
          end
        end
        default: tmr_st_r <= T_IDLE;
      endcase
    end
  end

  // Pulldown and measurement routing
  always_comb begin
    for (int p = 0; p < sld_pkg::NCH; p++) begin
      pd_nxt[p] = pd_all ||
                  (mon_en && (leak_ch[2:0] == 3'(p))) ||
                  (deploy_diag && dcr_r[p & 6].common_ret &&
                   (res_ch[2:1] == 2'(p >> 1)));
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      pulldown_off_out <= '0;
      mon_en_out <= 1'b0;
      fet_ch_out <= '0;
      source_en_out <= 1'b0;
      source_ch_out <= '0;
      amp_ch_out <= '0;
    end else begin
      pulldown_off_out <= pd_nxt;
      mon_en_out <= mon_en;
      fet_ch_out <= leak_ch[2:0];
      source_en_out <= res_meas;
      source_ch_out <= res_ch[2:0];
      // Partner amplifier makes shorted feeds read about half the loop
      amp_ch_out <= (ldr_mode == sld_pkg::MODE_CROSS_PAIR)
                    ? (res_ch[2:0] ^ 3'h1) : res_ch[2:0];
    end
  end

  // Read path
  always_comb begin
    rdata_nxt = '0;
    if (req.rd) begin
      if (req.addr == sld_pkg::ADDR_LOOP_DIAG_REQ) begin
        rdata_nxt = {18'h0, ldr_r};
      end else if (req.addr == sld_pkg::ADDR_LOOP_DIAG_STAT) begin
        rdata_nxt[0] = fet_res_valid_r ? stb_flag_r : hs_cmp;
        rdata_nxt[1] = fet_res_valid_r ? stg_flag_r : ls_cmp;
        rdata_nxt[2] = hs_fet_on_out || ls_fet_on_out;
        rdata_nxt[3] = fet_res_valid_r && (fet_st_r == F_IDLE) &&
                       (fet_is_hs_r ? (stb_flag_r && !stg_flag_r)
                                    : (!stb_flag_r && stg_flag_r));
        rdata_nxt[4] = fet_is_hs_r;
        rdata_nxt[5] = (tmr_st_r != T_IDLE);
        rdata_nxt[6] = fire_pin;
        rdata_nxt[7] = diag_ph;
        rdata_nxt[11:8] = leak_ch;
      end else if (req.addr == sld_pkg::ADDR_GND_LOSS) begin
        rdata_nxt[sld_pkg::NCH-1:0] = gnd_loss_r;
      end else if (req.addr == sld_pkg::ADDR_ADC_RESULT) begin
        rdata_nxt[ADC_W-1:0] = adc_res_r;
      end else if ((req.addr >= sld_pkg::ADDR_DEPLOY_CFG0) &&
                   (req.addr < sld_pkg::ADDR_DEPLOY_CFG0 + 8'(4 * sld_pkg::NCH)) &&
                   (req.addr[1:0] == 2'h0)) begin
        rdata_nxt[8:0] = dcr_r[req.addr[4:2]];
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= rdata_nxt;
    end
  end
endmodule

// [bench/sld_afe_model.sv]
`timescale 1ns/1ns
module sld_afe_model (
  input wire logic mclk_in,
  input wire logic trip_en_in,
  input wire logic hs_on_in,
  input wire logic ls_on_in,
  input wire logic adc_req_in,
  input wire logic fe_drv_in,
  input wire logic fe_oe_in,
  output logic hs_cmp_out = 1'b0,
  output logic ls_cmp_out = 1'b0,
  output logic adc_done_out,
  output logic [9:0] adc_data_out,
  output logic fe_pin_out
);
  int adc_cnt = 0;
  // Healthy FET pulls threshold current one cycle after turn-on
  always @(posedge mclk_in) begin
    hs_cmp_out <= trip_en_in & hs_on_in;
    ls_cmp_out <= trip_en_in & ls_on_in;
    if (adc_req_in)
      adc_cnt <= 6;
    else if (adc_cnt != 0)
      adc_cnt <= adc_cnt - 1;
  end
  assign adc_done_out = adc_cnt inside {1, 2};
  // Data bus shows junk outside the done window
  assign adc_data_out = adc_done_out ? 10'h2a5 : 10'h15a;
  // External pull-down holds the pin low when undriven
  assign fe_pin_out = fe_oe_in & fe_drv_in;
endmodule

// [bench/sld_top_props.sv]
`timescale 1ns/1ns
module sld_top_props #(
  parameter int FET_TO_CYC = 300
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic diag_phase_in,
  input wire logic hs_thr_cmp_in,
  input wire logic ls_thr_cmp_in,
  input wire logic adc_req_out,
  input wire logic fire_enable_pin_out,
  input wire logic fire_enable_pin_oe_out,
  input wire logic hs_fet_on_out,
  input wire logic ls_fet_on_out,
  input wire logic [2:0] fet_ch_out,
  input wire logic mon_en_out,
  input wire logic fet_deglitch_sel_out,
  input wire logic [sld_pkg::NCH-1:0] pulldown_off_out
);
  int on_cnt;
  int trip_cnt;
  wire fet_on = hs_fet_on_out | ls_fet_on_out;
  wire sys_wr = wr_in && addr_in == sld_pkg::ADDR_SYS_DIAG_REQ;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      on_cnt <= 0;
      trip_cnt <= 0;
    end else begin
      on_cnt <= fet_on ? on_cnt + 1 : 0;
      trip_cnt <= (fet_on && (hs_thr_cmp_in || ls_thr_cmp_in)) ? trip_cnt + 1 : 0;
    end
  end
  // Diag phase passes a two-flop sync, so look three cycles back
  property p_refuse;
    sys_wr && !fet_on && !diag_phase_in && !$past(diag_phase_in)
      && !$past(diag_phase_in, 2) && !$past(diag_phase_in, 3) |=> !fet_on;
  endproperty
  a_refuse: assert property (p_refuse) else $error("FET test ran outside diag");
  property p_one_fet; !(hs_fet_on_out && ls_fet_on_out); endproperty
  a_one_fet: assert property (p_one_fet) else $error("Both FETs under test");
  property p_start; $rose(fet_on) |-> fet_deglitch_sel_out && $past(sys_wr); endproperty
  a_start: assert property (p_start) else $error("FET start without arming");
  property p_trip; trip_cnt <= 210; endproperty
  a_trip: assert property (p_trip) else $error("Driver not cut on trip");
  property p_timeout; on_cnt <= FET_TO_CYC + 2; endproperty
  a_timeout: assert property (p_timeout) else $error("FET test outlived timeout");
  property p_disarm; $fell(fet_on) |-> ##[0:2] !fet_deglitch_sel_out; endproperty
  a_disarm: assert property (p_disarm) else $error("Deglitch not restored");
  property p_adc; wr_in && addr_in == sld_pkg::ADDR_DIAG_CTRL |=> adc_req_out ##1 !adc_req_out;
  endproperty
  a_adc: assert property (p_adc) else $error("No single ADC request");
  property p_pin_start; $rose(fire_enable_pin_oe_out) |-> $past(sys_wr); endproperty
  a_pin_start: assert property (p_pin_start) else $error("Pin driven unasked");
  property p_pin_oe; fire_enable_pin_out |-> fire_enable_pin_oe_out; endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("Pin high while not driven");
  property p_rdata; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("Read data outside slot");
  property p_mon_pd; mon_en_out |-> pulldown_off_out[fet_ch_out]; endproperty
  a_mon_pd: assert property (p_mon_pd) else $error("Pulldown on under monitor");
  c_fet_end: cover property ($fell(fet_on));
  c_adc: cover property (adc_req_out);
  c_pulse: cover property ($rose(fire_enable_pin_out));
endmodule
bind sld_top sld_top_props #(.FET_TO_CYC(FET_TO_CYC)) sld_top_props_inst (
  .mclk_in, .rstn_in, .addr_in, .wr_in, .rd_in, .rdata_out, .diag_phase_in,
  .hs_thr_cmp_in, .ls_thr_cmp_in, .adc_req_out, .fire_enable_pin_out,
  .fire_enable_pin_oe_out, .hs_fet_on_out, .ls_fet_on_out, .fet_ch_out,
  .mon_en_out, .fet_deglitch_sel_out, .pulldown_off_out
);

// [bench/test_squib_loop_diag_sequencer.sv]
`timescale 1ns/1ns
module test_squib_loop_diag_sequencer;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic diag_phase_in = 1'b0;
  logic gnd_open_cmp_in = 1'b0;
  logic trip_en = 1'b0;
  logic [31:0] rdata_out;
  logic [31:0] rd_val;
  logic hs_thr_cmp_in, ls_thr_cmp_in, adc_done_in, fire_enable_pin_in;
  logic [9:0] adc_data_in;
  logic fire_enable_pin_out, fire_enable_pin_oe_out, hs_fet_on_out, ls_fet_on_out;
  logic mon_en_out, fet_deglitch_sel_out, source_en_out, adc_req_out;
  logic [2:0] fet_ch_out, source_ch_out, amp_ch_out;
  logic [7:0] pulldown_off_out;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  always #5 mclk_in = ~mclk_in;
  // Short counts keep the run brief
  sld_top #(.FET_TO_CYC(300), .GAP_CYC(100), .GND_FILT_CYC(20)) sld_top_inst (
    .mclk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .diag_phase_in, .hs_thr_cmp_in, .ls_thr_cmp_in, .gnd_open_cmp_in, .adc_done_in,
    .adc_data_in, .fire_enable_pin_in, .fire_enable_pin_out, .fire_enable_pin_oe_out,
    .hs_fet_on_out, .ls_fet_on_out, .fet_ch_out, .mon_en_out, .fet_deglitch_sel_out,
    .pulldown_off_out, .source_en_out, .source_ch_out, .amp_ch_out, .adc_req_out
  );
  sld_afe_model sld_afe_model_inst (
    .mclk_in(mclk_in), .trip_en_in(trip_en), .hs_on_in(hs_fet_on_out),
    .ls_on_in(ls_fet_on_out), .adc_req_in(adc_req_out), .fe_drv_in(fire_enable_pin_out),
    .fe_oe_in(fire_enable_pin_oe_out), .hs_cmp_out(hs_thr_cmp_in),
    .ls_cmp_out(ls_thr_cmp_in), .adc_done_out(adc_done_in),
    .adc_data_out(adc_data_in), .fe_pin_out(fire_enable_pin_in)
  );
  task automatic tick(input int c);
    repeat (c) @(posedge mclk_in);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    tick(1);
    wr_in <= 1'b0;
    tick(1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    tick(1);
    rd_in <= 1'b0;
    rd_val = rdata_out;
    check(rd_val & m, e);
    tick(1);
  endtask
  task automatic wait_off(output int len);
    len = 0;
    while ((hs_fet_on_out | ls_fet_on_out) === 1'b1 && len < 1000) begin
      tick(1);
      len++;
    end
  endtask
  task automatic pulse_len(output int len);
    len = 0;
    for (int i = 0; i < 2000 && fire_enable_pin_out !== 1'b1; i++) tick(1);
    while (fire_enable_pin_out === 1'b1 && len < 20000) begin
      tick(1);
      len++;
    end
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #600000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    tick(3);
    rstn_in <= 1'b1;
    tick(6);
    rd_chk(8'hfc, 32'hffffffff, 32'h0);
    wr(8'h04, 32'h130);
    tick(4);
    check({mon_en_out, fet_ch_out, pulldown_off_out[3]}, 5'b10111);
    // Monitor already on, so only the phase input can refuse this
    wr(8'h00, 32'h11);
    check({hs_fet_on_out, fire_enable_pin_oe_out}, 2'b00);
    diag_phase_in <= 1'b1;
    tick(4);
    trip_en <= 1'b1;
    wr(8'h00, 32'h1);
    check({hs_fet_on_out, fet_deglitch_sel_out}, 2'b11);
    rd_chk(8'h08, 32'h4, 32'h4);
    wait_off(n);
    check(n <= 215, 1'b1);
    rd_chk(8'h08, 32'h1f, 32'h19);
    check(fet_deglitch_sel_out, 1'b0);
    wr(8'h04, 32'h130);
    rd_chk(8'h08, 32'h3, 32'h0);
    wr(8'h00, 32'h2);
    wait_off(n);
    rd_chk(8'h08, 32'h1f, 32'h0a);
    trip_en <= 1'b0;
    wr(8'h00, 32'h1);
    wait_off(n);
    check(n >= 295 && n <= 301, 1'b1);
    rd_chk(8'h08, 32'h1f, 32'h10);
    wr(8'h04, 32'h102);
    gnd_open_cmp_in <= 1'b1;
    tick(40);
    rd_chk(8'h0c, 32'hff, 32'h0);
    wr(8'h04, 32'h502);
    tick(40);
    // Ground back first, else the standing trip wins over the clearing read
    gnd_open_cmp_in <= 1'b0;
    tick(4);
    rd_chk(8'h0c, 32'hff, 32'h04);
    rd_chk(8'h0c, 32'hff, 32'h0);
    wr(8'h04, 32'h1d02);
    tick(2);
    check({source_en_out, source_ch_out, amp_ch_out}, 7'b1010011);
    wr(8'h20, 32'h80);
    wr(8'h24, 32'h2);
    wr(8'h04, 32'h2000);
    tick(2);
    check(pulldown_off_out[1:0], 2'b11);
    rd_chk(8'h24, 32'h1ff, 32'h102);
    wr(8'h10, 32'h0);
    tick(12);
    rd_chk(8'h14, 32'h3ff, 32'h2a5);
    wr(8'h00, 32'h10);
    pulse_len(n);
    check(n, 32'd12800);
    pulse_len(n);
    check(n, 32'd800);
    check(fire_enable_pin_oe_out, 1'b1);
    tick(6000);
    wr(8'h00, 32'h20);
    check(fire_enable_pin_out, 1'b1);
    // Pin readback passes the two-flop sync first
    tick(2);
    rd_chk(8'h08, 32'h40, 32'h40);
    tick(794);
    check(fire_enable_pin_out, 1'b1);
    tick(1);
    check(fire_enable_pin_out, 1'b0);
    wrap_up();
  end
endmodule
